// ### hw/ubf_config.sv
// Baud divisor, frame control and event interrupt logic of the serial port.
// Assumes synchronous inputs, a single clock and strobes from a plain master.
//
// Implementation choices: the placing of the registers and strobed register access.
`include "ubf_defs.svh"

module ubf_config
    import ubf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [`UBF_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic cpu_wait,
    input wire logic lin_break_flag,
    input wire logic rx_edge_flag,
    input wire logic tx_serial,
    input wire logic rxd_pin,
    input wire logic txd_pin_in,
    output logic txd_pin_out,
    output logic txd_pin_oe,
    output logic rx_serial,
    output logic baud_tick,
    output ubf_frame_s frame_cfg,
    output logic irq
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] bdh_ff;
    logic [4:0] div_hi_work_ff;
    logic [7:0] bdl_ff;
    ubf_ctl1_s ctl1_ff;
    logic [2:0] ctl2_ff;
    logic [2:0] stat_ff;
    logic [2:0] mask_ff;
    logic [12:0] cnt_ff;
    ubf_gen_e gen_ff;
    ubf_gen_e nxt_gen;
    logic tick_ff;
    logic lbk_prev_ff;
    logic rxe_prev_ff;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire wr_bdh = clk_en && reg_wr && reg_addr == `UBF_OFF_BDH;
    wire wr_bdl = clk_en && reg_wr && reg_addr == `UBF_OFF_BDL;
    wire wr_ctl1 = clk_en && reg_wr && reg_addr == `UBF_OFF_CTL1;
    wire wr_ctl2 = clk_en && reg_wr && reg_addr == `UBF_OFF_CTL2;
    wire wr_stat = clk_en && reg_wr && reg_addr == `UBF_OFF_STAT;
    wire wr_mask = clk_en && reg_wr && reg_addr == `UBF_OFF_MASK;

    wire [12:0] combined_divisor = {div_hi_work_ff, bdl_ff}; // R6
    wire div_zero = combined_divisor == 13'h0000; // R4
    wire enable_written = wr_ctl2 && (reg_wdata[`UBF_CTL2_TE] || reg_wdata[`UBF_CTL2_RE]);
    // Wait freeze stops the divider; flags still reach the interrupt so wakeup works
    wire freeze = ctl1_ff.wait_clock_freeze && cpu_wait; // R10
    wire gen_step = clk_en && !freeze && gen_ff == UBF_RUN && !div_zero;
    wire cnt_reload = cnt_ff == 13'h0001 || cnt_ff == 13'h0000;
    wire loop_on = ctl1_ff.loop_select; // R9
    wire single_wire = loop_on && ctl1_ff.receiver_source_select; // R11
    wire drive_tx = single_wire ? ctl2_ff[`UBF_CTL2_SINGLE_WIRE_DIRECTION] : ctl2_ff[`UBF_CTL2_TE]; // R17
    wire [2:0] ev_now = {tick_ff, rx_edge_flag && !rxe_prev_ff, lin_break_flag && !lbk_prev_ff};
    wire [7:0] rd_mux =
        reg_addr == `UBF_OFF_BDH ? {bdh_ff[7:5], 5'h00} | {3'h0, div_hi_work_ff} :
        reg_addr == `UBF_OFF_BDL ? bdl_ff :
        reg_addr == `UBF_OFF_CTL1 ? ctl1_ff :
        reg_addr == `UBF_OFF_CTL2 ? {5'h00, ctl2_ff} :
        reg_addr == `UBF_OFF_STAT ? {5'h00, stat_ff} :
        reg_addr == `UBF_OFF_MASK ? {5'h00, mask_ff} : 8'h00;

    // ------------------------------------------------------------
    // Generator state
    // ------------------------------------------------------------
    always_comb begin
        case (gen_ff)
            UBF_OFF: nxt_gen = enable_written ? UBF_RUN : UBF_OFF; // R3
            UBF_ARMED: nxt_gen = UBF_RUN;
            UBF_RUN: nxt_gen = UBF_RUN;
            default: nxt_gen = UBF_OFF;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bdh_ff <= 8'h00;
            div_hi_work_ff <= 5'h00;
            bdl_ff <= `UBF_BDL_RST;
            ctl1_ff <= '0;
            ctl2_ff <= 3'h0;
            mask_ff <= 3'h0;
            gen_ff <= UBF_OFF;
        end else if (clk_en) begin
            gen_ff <= nxt_gen;
            if (wr_bdh) bdh_ff <= reg_wdata; // R1
            if (wr_bdl) begin
                bdl_ff <= reg_wdata;
                div_hi_work_ff <= bdh_ff[`UBF_BDH_DIV_HI]; // R2
            end
            if (wr_ctl1) ctl1_ff <= reg_wdata;
            if (wr_ctl2) ctl2_ff <= reg_wdata[2:0];
            if (wr_mask) mask_ff <= reg_wdata[2:0];
        end
    end

    // ------------------------------------------------------------
    // Baud divider: each reload is one oversample tick at 16x bit rate
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt_ff <= 13'h0000;
            tick_ff <= 1'b0;
        end else if (clk_en) begin
            tick_ff <= gen_step && cnt_reload; // R5 R18
            if (!gen_step) cnt_ff <= combined_divisor; // R4
            else if (cnt_reload) cnt_ff <= combined_divisor; // R18
            else cnt_ff <= cnt_ff - 13'h0001;
        end
    end

    // ------------------------------------------------------------
    // Events and interrupt; set wins over write-one clear
    // ------------------------------------------------------------
    generate
        for (genvar i = 0; i < 3; i++) begin : g_stat
            always_ff @(posedge core_clk) begin
                if (!rst_n) stat_ff[i] <= 1'b0;
                else if (clk_en) stat_ff[i] <= ev_now[i] || (stat_ff[i] && !(wr_stat && reg_wdata[i]));
            end
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            lbk_prev_ff <= 1'b0;
            rxe_prev_ff <= 1'b0;
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            lbk_prev_ff <= lin_break_flag;
            rxe_prev_ff <= rx_edge_flag;
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // Level requests follow the flags themselves, as well as latched status
    assign irq = (bdh_ff[`UBF_BDH_LBKIE] && lin_break_flag) // R7
        || (bdh_ff[`UBF_BDH_RXEIE] && rx_edge_flag) // R8
        || |(stat_ff & mask_ff);

    // ------------------------------------------------------------
    // Pin routing and frame outputs
    // ------------------------------------------------------------
    assign rx_serial = !loop_on ? rxd_pin : (single_wire ? txd_pin_in : tx_serial); // R9 R11
    assign txd_pin_out = tx_serial;
    assign txd_pin_oe = drive_tx && !(loop_on && !single_wire); // R17
    assign baud_tick = tick_ff;
    assign frame_cfg.nine_bit = ctl1_ff.nine_bit; // R12
    assign frame_cfg.wake_address_mark = ctl1_ff.wake_address_mark; // R13
    assign frame_cfg.idle_after_stop = ctl1_ff.idle_count_start_select; // R14
    assign frame_cfg.parity_enable = ctl1_ff.parity_enable; // R15
    assign frame_cfg.parity_odd = ctl1_ff.parity_sense; // R16

endmodule

// ### shared/ubf_defs.svh
// Constants for the serial port baud and frame configuration block.
// Assumes one synchronous clock and the plain strobe register port.
//
// Overview of operation
// R1 - Software writes divisor high register first, then low register; high write is buffered.
// R2 - Working high divisor bits change only when the low register is written.
// R3 - Baud generator stays off after reset until receiver or transmitter enable written one.
// R4 - Combined divisor of zero stops the baud generator to save current.
// R5 - Divisor 1..8191 gives bit rate of clock over sixteen times divisor.
// R6 - Divisor upper five bits in high bits 4:0, lower eight in low 7:0.
// R7 - High register bit 7 enables interrupt while the LIN break flag is set.
// R8 - High register bit 6 enables interrupt while the receive edge flag is set.
// R9 - Loop select routes transmitter to receiver internally and ignores the receive pin.
// R10 - Control bit 6 one freezes serial clocks during wait mode.
// R11 - Receiver source matters only in loop mode: zero internal, one single-wire.
// R12 - Control bit 4 selects eight or nine data bits per character.
// R13 - Control bit 3 picks idle-line or address-mark receiver wakeup.
// R14 - Control bit 2 picks idle count start after start bit or stop bit.
// R15 - Parity enable makes hardware generate and check parity in the top data bit.
// R16 - Parity sense zero even, one odd, counting the parity bit too.
// R17 - In single-wire mode a direction bit decides if transmit pin drives or receives.
// R18 - Baud generator is a reloading down-counter giving one tick per reload.
`ifndef UBF_DEFS_SVH
`define UBF_DEFS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define UBF_ADDR_W 3
`define UBF_OFF_BDH 3'h0
`define UBF_OFF_BDL 3'h1
`define UBF_OFF_CTL1 3'h2
`define UBF_OFF_CTL2 3'h3
`define UBF_OFF_STAT 3'h4
`define UBF_OFF_MASK 3'h5

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define UBF_BDH_LBKIE 7
`define UBF_BDH_RXEIE 6
`define UBF_BDH_DIV_HI 4:0
`define UBF_BDL_RST 8'h04
`define UBF_CTL2_SINGLE_WIRE_DIRECTION 2
`define UBF_CTL2_TE 1
`define UBF_CTL2_RE 0
`define UBF_ST_LBK 0
`define UBF_ST_RXE 1
`define UBF_ST_TICK 2
`define UBF_OVERSAMPLE 16

`endif

// ### shared/ubf_pkg.sv
// Types for the baud and frame configuration block.
// Assumes the defines header is compiled alongside.
package ubf_pkg;
    typedef struct packed {
        logic loop_select;
        logic wait_clock_freeze;
        logic receiver_source_select;
        logic nine_bit;
        logic wake_address_mark;
        logic idle_count_start_select;
        logic parity_enable;
        logic parity_sense;
    } ubf_ctl1_s;

    typedef struct packed {
        logic nine_bit;
        logic parity_enable;
        logic parity_odd;
        logic wake_address_mark;
        logic idle_after_stop;
    } ubf_frame_s;

    typedef enum logic [2:0] {
        UBF_OFF = 3'b001,
        UBF_ARMED = 3'b010,
        UBF_RUN = 3'b100
    } ubf_gen_e;
endpackage

// ### verification/ubf_config_properties.sv
// Port checker for the baud and frame configuration block.
// Assumes control register one resets to zero and clk_en stays high.
`include "ubf_defs.svh"
module ubf_config_properties
    import ubf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [`UBF_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic tx_serial,
    input wire logic rxd_pin,
    input wire logic txd_pin_in,
    input wire logic txd_pin_out,
    input wire logic txd_pin_oe,
    input wire logic rx_serial,
    input wire logic baud_tick,
    input wire ubf_frame_s frame_cfg,
    input wire logic irq
);
    // ------------------------------------------------------------
    // Shadow of control one and generator arming
    // ------------------------------------------------------------
    logic [7:0] ctl_ff;
    logic gen_ff;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctl_ff <= 8'h00;
            gen_ff <= 1'b0;
        end else if (clk_en && reg_wr) begin
            if (reg_addr == 3'h2) ctl_ff <= reg_wdata;
            if (reg_addr == 3'h3 && reg_wdata[1:0] != 2'h0) gen_ff <= 1'b1;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    rdata_idle_a: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read");
    ctl_read_a: assert property (clk_en && reg_rd && reg_addr == 3'h2 |=> reg_rdata == $past(ctl_ff))
        else $error("control one read back wrong");
    frame_map_a: assert property ({frame_cfg.nine_bit, frame_cfg.parity_enable,
        frame_cfg.wake_address_mark, frame_cfg.idle_after_stop} == {ctl_ff[4], ctl_ff[1],
        ctl_ff[3], ctl_ff[2]}) else $error("frame settings differ from control one");
    parity_sense_a: assert property (ctl_ff[1] |-> frame_cfg.parity_odd == ctl_ff[0])
        else $error("parity sense wrong");
    loop_rx_a: assert property (ctl_ff[7] && !ctl_ff[5] |-> rx_serial == tx_serial)
        else $error("loop mode receiver input wrong");
    loop_oe_a: assert property (ctl_ff[7] && !ctl_ff[5] |-> !txd_pin_oe)
        else $error("pin driven in internal loop");
    wire_rx_a: assert property (ctl_ff[7] && ctl_ff[5] |-> rx_serial == txd_pin_in)
        else $error("single wire receiver input wrong");
    pin_rx_a: assert property (!ctl_ff[7] |-> rx_serial == rxd_pin)
        else $error("normal receiver input wrong");
    tick_off_a: assert property (!gen_ff |-> !baud_tick)
        else $error("tick before any enable");
    pin_drive_a: assert property (txd_pin_out == tx_serial)
        else $error("transmit pin not fed from transmitter");
    cover property (ctl_ff[7] && ctl_ff[5] && txd_pin_oe);
    cover property (irq);
    cover property (baud_tick);
endmodule
bind ubf_config ubf_config_properties chk_i (.core_clk, .rst_n, .clk_en, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_serial, .rxd_pin, .txd_pin_in,
    .txd_pin_out, .txd_pin_oe, .rx_serial, .baud_tick, .frame_cfg, .irq);

// ### verification/ubf_remote_node.sv
// Remote node on the serial line.
// Assumes the shared wire has no pull, so an undriven wire toggles.
module ubf_remote_node (
    input wire logic core_clk,
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic rxd_pin,
    output logic wire_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pat_ff = 1'b1;
    always_ff @(posedge core_clk) pat_ff <= ~pat_ff;
    assign rxd_pin = pat_ff;
    assign wire_lvl = pin_oe ? pin_out : ~pat_ff;
endmodule

// ### verification/ubf_config_tb_top.sv
// Testbench for the baud and frame configuration block.
// Assumes mask and control registers reset to zero.
module ubf_config_tb_top;
    import ubf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, rst_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, cpu_wait = 0;
    logic lin_break_flag = 0, rx_edge_flag = 0, tx_serial = 0;
    logic [2:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata;
    logic rxd_pin, txd_pin_in, txd_pin_out, txd_pin_oe, rx_serial, baud_tick, irq;
    ubf_frame_s frame_cfg;
    int n_errors = 0, checks = 0, k;
    // Control one value beside its frame settings
    logic [12:0] rows [5] = '{13'h0210, 13'h0048, 13'h006C, 13'h0102, 13'h0081};
    always #4 core_clk = ~core_clk;
    ubf_config uut (.core_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .cpu_wait, .lin_break_flag, .rx_edge_flag, .tx_serial, .rxd_pin,
        .txd_pin_in, .txd_pin_out, .txd_pin_oe, .rx_serial, .baud_tick, .frame_cfg, .irq);
    ubf_remote_node peer (.core_clk, .pin_out(txd_pin_out), .pin_oe(txd_pin_oe), .rxd_pin,
        .wire_lvl(txd_pin_in));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1;
        @(posedge core_clk);
        reg_wr <= 0;
        #1;
    endtask
    task rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a; reg_rd <= 1;
        @(posedge core_clk);
        reg_rd <= 0;
        #1 chk(reg_rdata, exp);
    endtask
    // Sliding count is exact for any window that is a multiple of the period
    task ticks(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge core_clk);
            #1 if (baud_tick === 1'b1) c++;
        end
    endtask
    task results;
        $display("n_errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1;
        #1 chk(irq, 0);
        chk(txd_pin_oe, 0);
        ticks(12, k); chk(k[7:0], 0);
        foreach (rows[i]) begin
            wr(3'h2, rows[i][12:5]);
            chk({3'h0, frame_cfg}, {3'h0, rows[i][4:0]});
            rd(3'h2, rows[i][12:5]);
        end
        wr(3'h0, 8'h00); wr(3'h1, 8'h03); wr(3'h3, 8'h02);
        ticks(5, k); ticks(30, k); chk(k[7:0], 10);
        wr(3'h0, 8'h01); ticks(30, k); chk(k[7:0], 10);
        rd(3'h0, 8'h00);
        wr(3'h1, 8'h00); rd(3'h0, 8'h01);
        wr(3'h0, 8'h00); wr(3'h1, 8'h00); ticks(30, k); chk(k[7:0], 0);
        wr(3'h1, 8'h03); wr(3'h2, 8'h40);
        @(posedge core_clk);
        cpu_wait <= 1;
        ticks(30, k); chk(k[7:0], 0);
        @(posedge core_clk);
        cpu_wait <= 0;
        ticks(30, k); chk(k[7:0], 10);
        wr(3'h2, 8'h80);
        for (int v = 0; v < 2; v++) begin
            @(posedge core_clk);
            tx_serial <= v[0];
            #1 chk(rx_serial, v[7:0]);
            chk(txd_pin_oe, 0);
            chk(txd_pin_out, v[7:0]);
        end
        wr(3'h3, 8'h06); wr(3'h2, 8'hA0);
        chk(txd_pin_oe, 1); chk(rx_serial, tx_serial);
        wr(3'h3, 8'h02); chk(txd_pin_oe, 0); chk(rx_serial, !rxd_pin);
        wr(3'h2, 8'h00); chk(rx_serial, rxd_pin); chk(txd_pin_oe, 1);
        wr(3'h0, 8'h80);
        @(posedge core_clk);
        lin_break_flag <= 1;
        #1 chk(irq, 1);
        wr(3'h0, 8'h00); chk(irq, 0);
        wr(3'h5, 8'h01); chk(irq, 1); wr(3'h4, 8'h01); chk(irq, 0);
        wr(3'h0, 8'h40);
        @(posedge core_clk);
        rx_edge_flag <= 1;
        #1 chk(irq, 1);
        wr(3'h0, 8'h00); chk(irq, 0);
        // Lin break cleared, receive edge and tick still latched
        rd(3'h4, 8'h06);
        rd(3'h5, 8'h01);
        rd(3'h3, 8'h02);
        rd(3'h7, 8'h00);
        // ------------------------------------------------------------
        // Reset in mid-run
        // ------------------------------------------------------------
        @(posedge core_clk);
        lin_break_flag <= 0;
        rx_edge_flag <= 0;
        rst_n <= 0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1;
        #1 chk(txd_pin_oe, 0);
        chk(irq, 0);
        rd(3'h1, 8'h04);
        rd(3'h0, 8'h00);
        rd(3'h2, 8'h00);
        ticks(12, k); chk(k[7:0], 0);
        // Receiver enable alone starts the generator on the reset divisor
        wr(3'h3, 8'h01);
        ticks(4, k);
        ticks(40, k); chk(k[7:0], 10);
        results;
    end
endmodule
